/* logic/wdpt_top.sv */
// watchdog and periodic tick timer, top level
`timescale 1ns/1ps
`default_nettype none
module wdpt_top
    import wdpt_pkg::*;
(
    // clock, system reset, power-on reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic por_arst_n,
    // timebase pin from the clock module
    input wire logic timebase_clock,
    // peripheral bus
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    // events
    output logic system_reset_req,
    output logic periodic_irq
);
    // ==========================================================
    // tap selection
    // watchdog: codes 0 and 1 direct, codes 2..7 free taps 0..5
    function automatic logic wd_tap(input logic [2:0] sel,
                                    input logic tick,
                                    input logic [6:0] carry);
        if (sel < WD_SEL_FIRST_TAP) begin
            return tick;
        end
        return carry[sel - WD_SEL_FIRST_TAP];
    endfunction : wd_tap

    function automatic logic p_tap(input logic [2:0] sel,
                                   input logic [6:0] fcarry,
                                   input logic [7:0] pcarry);
        case (sel[1:0])
            2'h0: return sel[2] ? pcarry[P_FREE_TAP0] : fcarry[P_FREE_TAP0];
            2'h1: return sel[2] ? pcarry[P_FREE_TAP1] : fcarry[P_FREE_TAP1];
            2'h2: return sel[2] ? pcarry[P_FREE_TAP2] : fcarry[P_FREE_TAP2];
            default: return sel[2] ? pcarry[P_FREE_TAP3]
                                   : fcarry[P_FREE_TAP3];
        endcase
    endfunction : p_tap

    // ==========================================================
    // timebase
    wdpt_time_if tb ();

    wdpt_free_counter wdpt_free_counter_inst (
        .clk(clk),
        .arst_n(arst_n),
        .timebase_clock(timebase_clock),
        .tb(tb)
    );

    // ==========================================================
    // bus decode
    logic wr_pcount;
    logic wr_key;
    logic wr_pctl;
    logic wr_wctl;
    logic [7:0] wbyte;

    // only the low byte lane is ever used
    assign wbyte = bus_wdata[7:0];
    assign wr_pcount = bus_wr && bus_addr == ADDR_PERIODIC_COUNT;
    assign wr_key = bus_wr && bus_addr == ADDR_SERVICE_KEY;
    assign wr_pctl = bus_wr && bus_addr == ADDR_PERIODIC_CONTROL;
    assign wr_wctl = bus_wr && bus_addr == ADDR_WATCHDOG_CONTROL;

    // ==========================================================
    // periodic counter, fed by the free counter overflow (/128)
    logic [COUNT_WIDTH-1:0] pcount_q;
    logic [COUNT_WIDTH-1:0] pcarry;
    logic pclk;

    assign pclk = tb.free_carry[FREE_WIDTH-1];

    genvar k;
    generate
        for (k = 0; k < COUNT_WIDTH; k++) begin : g_ptap
            assign pcarry[k] = pclk & (&pcount_q[k:0]);
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pcount_q <= COUNT_RESET;
        end else if (wr_pcount) begin
            // clearing does not touch the free counter: first period
            // after a clear is uncertain by one free tap
            pcount_q <= COUNT_RESET;
        end else if (pclk) begin
            pcount_q <= pcount_q + 1'b1;
        end
    end

    // ==========================================================
    // periodic control and interrupt
    logic pflag_q;
    logic penable_q;
    logic [2:0] psel_q;
    logic pevent;

    assign pevent = p_tap(psel_q, tb.free_carry, pcarry);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            penable_q <= 1'b0;
            psel_q <= SEL_RESET;
        end else if (wr_pctl) begin
            penable_q <= wbyte[PENABLE_BIT];
            psel_q <= wbyte[SEL_HI:SEL_LO];
        end
    end

    // a software write of one only stores; it raises no interrupt
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pflag_q <= 1'b0;
        end else if (pevent) begin
            pflag_q <= 1'b1;
        end else if (wr_pctl) begin
            pflag_q <= wbyte[FLAG_BIT];
        end
    end

    // pevent is a one-cycle carry, so one request per tap transition
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            periodic_irq <= 1'b0;
        end else begin
            periodic_irq <= pevent && penable_q;
        end
    end

    a_irq_gate: assert property (
        @(posedge clk) disable iff (!arst_n)
        periodic_irq |-> $past(penable_q) && pflag_q)
        else $error("interrupt without enable");

    a_irq_single: assert property (
        @(posedge clk) disable iff (!arst_n)
        periodic_irq |=> !periodic_irq)
        else $error("more than one request per transition");

    a_pflag_set: assert property (
        @(posedge clk) disable iff (!arst_n)
        pevent |=> pflag_q)
        else $error("periodic flag not set");

    c_irq: cover property (@(posedge clk) disable iff (!arst_n)
        periodic_irq);

    // ==========================================================
    // watchdog control
    logic [2:0] chk_q;
    logic [2:0] wsel_q;
    logic wtick;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chk_q <= CHK_PATTERN;
            wsel_q <= SEL_RESET;
        end else if (wr_wctl) begin
            chk_q <= wbyte[CHK_HI:CHK_LO];
            wsel_q <= wbyte[SEL_HI:SEL_LO];
        end
    end

    a_check_bits: assert property (
        @(posedge clk) disable iff (!arst_n)
        wr_wctl && wbyte[CHK_HI:CHK_LO] != CHK_PATTERN
        |=> ##1 system_reset_req)
        else $error("bad check pattern did not reset");

    assign wtick = wd_tap(wsel_q, tb.tick, tb.free_carry);

    // ==========================================================
    // key sequence and watchdog counter
    logic armed_q;
    logic key_clear;
    logic key_bad;
    logic [COUNT_WIDTH-1:0] wcount_q;
    logic ovf_pend_q;

    assign key_clear = wr_key && wbyte == KEY_CLEAR && armed_q;
    assign key_bad = wr_key && wbyte != KEY_CLEAR
                     && wbyte != KEY_ARM;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_q <= 1'b0;
        end else if (wr_key && wbyte == KEY_ARM) begin
            armed_q <= 1'b1;
        end else if (wr_key) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wcount_q <= COUNT_RESET;
        end else if (key_clear) begin
            wcount_q <= COUNT_RESET;
        end else if (wtick) begin
            wcount_q <= wcount_q + 1'b1;
        end
    end

    a_key_clear_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        key_clear |=> wcount_q == COUNT_RESET)
        else $error("key sequence did not clear counter");

    a_read_stable: assert property (
        @(posedge clk) disable iff (!arst_n)
        bus_rd && !wtick && !key_clear |=> $stable(wcount_q))
        else $error("read disturbed watchdog count");

    c_service: cover property (@(posedge clk) disable iff (!arst_n)
        key_clear);

    // overflow waits one more selected clock before the reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovf_pend_q <= 1'b0;
        end else if (wtick && wcount_q == COUNT_MAX && !key_clear) begin
            ovf_pend_q <= 1'b1;
        end
    end

    // ==========================================================
    // system reset request and reset-source flag
    logic wd_cause;
    logic wflag_q;

    // the check bits are watched every cycle, not just on writes
    assign wd_cause = key_bad || chk_q != CHK_PATTERN
                      || (ovf_pend_q && wtick);

    // held until the system reset it asks for comes back
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            system_reset_req <= 1'b0;
        end else if (wd_cause) begin
            system_reset_req <= 1'b1;
        end
    end

    a_key_bad_reset: assert property (
        @(posedge clk) disable iff (!arst_n)
        key_bad |=> system_reset_req)
        else $error("bad key did not request reset");

    a_chk_watch: assert property (
        @(posedge clk) disable iff (!arst_n)
        chk_q != CHK_PATTERN |=> system_reset_req)
        else $error("corrupt check bits did not reset");

    a_ovf_delay: assert property (
        @(posedge clk) disable iff (!arst_n)
        ovf_pend_q && wtick |=> system_reset_req)
        else $error("overflow reset late");

    a_ovf_early: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(ovf_pend_q) && !$past(key_bad) && chk_q == CHK_PATTERN
        |-> !system_reset_req)
        else $error("overflow reset came too early");

    c_overflow: cover property (@(posedge clk) disable iff (!arst_n)
        ovf_pend_q && wtick);

    c_bad_check: cover property (@(posedge clk) disable iff (!arst_n)
        chk_q != CHK_PATTERN);

    // survives system reset; power-on or a write of one to the flag clears it. set beats clear
    always_ff @(posedge clk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            wflag_q <= 1'b0;
        end else if (wd_cause) begin
            wflag_q <= 1'b1;
        end else if (wr_wctl && wbyte[FLAG_BIT]) begin
            wflag_q <= 1'b0;
        end
    end

    a_flag_set: assert property (
        @(posedge clk) disable iff (!por_arst_n)
        wd_cause |=> wflag_q)
        else $error("reset flag not set");

    // ==========================================================
    // read data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= '0;
        end else if (bus_rd) begin
            bus_rdata[15:8] <= BYTE_ZERO;
            unique case (bus_addr)
                ADDR_PERIODIC_COUNT: bus_rdata[7:0] <= pcount_q;
                ADDR_WATCHDOG_COUNT: bus_rdata[7:0] <= wcount_q;
                ADDR_PERIODIC_CONTROL: begin
                    bus_rdata[7:0] <= {pflag_q, penable_q, 3'h0, psel_q};
                end
                ADDR_WATCHDOG_CONTROL: begin
                    bus_rdata[7:0] <= {wflag_q, 1'b0, chk_q, wsel_q};
                end
                default: bus_rdata[7:0] <= BYTE_ZERO;
            endcase
        end
    end

    a_upper_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        bus_rdata[15:8] == BYTE_ZERO)
        else $error("upper read byte not zero");
endmodule : wdpt_top
`default_nettype wire

/* logic/wdpt_pkg.sv */
// constants shared by the watchdog and periodic tick timer
`default_nettype none
package wdpt_pkg;
    // ==========================================================
    // register addresses on the peripheral bus
    localparam logic [15:0] ADDR_PERIODIC_COUNT = 16'h7021;
    localparam logic [15:0] ADDR_WATCHDOG_COUNT = 16'h7023;
    localparam logic [15:0] ADDR_SERVICE_KEY = 16'h7025;
    localparam logic [15:0] ADDR_PERIODIC_CONTROL = 16'h7027;
    localparam logic [15:0] ADDR_WATCHDOG_CONTROL = 16'h7029;
    // ==========================================================
    // field positions
    localparam int FLAG_BIT = 7;
    localparam int PENABLE_BIT = 6;
    localparam int CHK_HI = 5;
    localparam int CHK_LO = 3;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 0;
    // ==========================================================
    // values
    localparam logic [7:0] KEY_ARM = 8'h55;
    localparam logic [7:0] KEY_CLEAR = 8'haa;
    localparam logic [2:0] CHK_PATTERN = 3'h5;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int FREE_WIDTH = 7;
    localparam int COUNT_WIDTH = 8;
    // nominal timebase rate; direct overflow is 256 ticks, 15.63 ms
    localparam int TIMEBASE_HZ = 16384;
    // watchdog select codes below this use the timebase directly
    localparam logic [2:0] WD_SEL_FIRST_TAP = 3'h2;
    // periodic select: codes 0..3 free taps, 4..7 periodic taps
    typedef logic [1:0] wdpt_tapidx_t;
    localparam logic [2:0] P_FREE_TAP0 = 3'h1;
    localparam logic [2:0] P_FREE_TAP1 = 3'h3;
    localparam logic [2:0] P_FREE_TAP2 = 3'h5;
    localparam logic [2:0] P_FREE_TAP3 = 3'h6;
endpackage : wdpt_pkg
`default_nettype wire

/* logic/wdpt_time_if.sv */
// timebase tick and free-running counter taps
`timescale 1ns/1ps
`default_nettype none
interface wdpt_time_if;
    logic tick;
    logic [6:0] free_value;
    logic [6:0] free_carry;
    modport source (output tick, output free_value, output free_carry);
    modport sink (input tick, input free_value, input free_carry);
endinterface : wdpt_time_if
`default_nettype wire

/* logic/wdpt_free_counter.sv */
// timebase pin synchroniser and 7-bit free-running counter
`timescale 1ns/1ps
`default_nettype none
module wdpt_free_counter
    import wdpt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // timebase pin
    input wire logic timebase_clock,
    // ticks and taps
    wdpt_time_if.source tb
);
    // ==========================================================
    // synchroniser
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic [FREE_WIDTH-1:0] free_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= timebase_clock;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // only a rising timebase edge advances anything; no register bit
    // can stop it, only the absent clock in oscillator power-down
    assign tb.tick = sync2_q & ~sync3_q;

    // ==========================================================
    // free-running counter, cleared by system reset only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            free_q <= '0;
        end else if (tb.tick) begin
            free_q <= free_q + 1'b1;
        end
    end

    assign tb.free_value = free_q;

    a_free_step: assert property (
        @(posedge clk) disable iff (!arst_n)
        tb.tick |=> free_q == $past(free_q) + 1'b1)
        else $error("free counter did not advance");

    a_free_hold: assert property (
        @(posedge clk) disable iff (!arst_n)
        !tb.tick |=> $stable(free_q))
        else $error("free counter moved without a tick");

    // carry out of bits k..0: tap k divides the timebase by 2^(k+1)
    genvar k;
    generate
        for (k = 0; k < FREE_WIDTH; k++) begin : g_tap
            assign tb.free_carry[k] = tb.tick & (&free_q[k:0]);
        end
    endgenerate
endmodule : wdpt_free_counter
`default_nettype wire

/* tb/wdpt_cpu_model.sv */
// processor-side master of the peripheral bus
`timescale 1ns/1ps
`default_nettype none
module wdpt_cpu_model (
    // clock
    input wire logic clk,
    // peripheral bus
    output logic [15:0] bus_addr,
    output logic [15:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input wire logic [15:0] bus_rdata
);
    initial begin
        bus_addr = 16'h0000;
        bus_wdata = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end

    // ==========================================================
    // one-cycle strobes, launched and dropped on falling edges
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        // released lines must not keep the last value
        bus_addr = ~a;
        bus_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        d = bus_rdata;
        bus_rd = 1'b0;
        bus_addr = ~a;
    endtask : rd
endmodule : wdpt_cpu_model
`default_nettype wire

/* tb/tb_wdpt_top.sv */
// self-checking bench of the watchdog and periodic tick timer
`timescale 1ns/1ps
`default_nettype none
module tb_wdpt_top
    import wdpt_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic por_arst_n = 1'b0;
    logic timebase_clock = 1'b0;
    logic [15:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic bus_wr;
    logic bus_rd;
    logic system_reset_req;
    logic periodic_irq;
    int num_errors = 0;
    int checks = 0;
    int irq_n = 0;
    int tk = 0;
    int t0;
    int dv;
    int i0;

    always #2.5 clk = ~clk;
    always @(negedge clk) if (periodic_irq === 1'b1) irq_n++;

    wdpt_top wdpt_top_inst (.clk(clk), .arst_n(arst_n),
        .por_arst_n(por_arst_n), .timebase_clock(timebase_clock),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .system_reset_req(system_reset_req), .periodic_irq(periodic_irq));

    wdpt_cpu_model wdpt_cpu_model_inst (.clk(clk), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata));

    // ==========================================================
    // reporting
    task automatic end_sim();
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    // ==========================================================
    // bus and stimulus helpers
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        wdpt_cpu_model_inst.wr(a, d);
    endtask : wr

    task automatic rdc(input string n, input logic [15:0] a,
                       input logic [7:0] e);
        logic [15:0] d;
        wdpt_cpu_model_inst.rd(a, d);
        // upper byte always reads zero, only the low byte is judged
        chk(n, e, d[7:0]);
    endtask : rdc

    task automatic svc();
        wr(ADDR_SERVICE_KEY, 16'h0055);
        wr(ADDR_SERVICE_KEY, 16'h00aa);
    endtask : svc

    // timebase stands still between bursts so counts are exact
    task automatic tick(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            timebase_clock = 1'b1;
            repeat (2) @(negedge clk);
            timebase_clock = 1'b0;
            @(negedge clk);
            tk++;
        end
        repeat (4) @(negedge clk);
    endtask : tick

    task automatic wait_req(input int lim);
        for (int i = 0; i < lim && system_reset_req !== 1'b1; i++) begin
            @(negedge clk);
        end
        chk1("system_reset_req", 1'b1, system_reset_req);
        if (system_reset_req !== 1'b1) end_sim();
    endtask : wait_req

    task automatic do_rst(input logic por_keep);
        @(negedge clk);
        arst_n = 1'b0;
        por_arst_n = por_keep;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        por_arst_n = 1'b1;
        tk = 0;
    endtask : do_rst

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        do_rst(1'b0);
        rdc("wd_ctrl", ADDR_WATCHDOG_CONTROL, 8'h28);
        rdc("p_ctrl", ADDR_PERIODIC_CONTROL, 8'h00);
        rdc("key", ADDR_SERVICE_KEY, 8'h00);
        rdc("unmapped", 16'h7020, 8'h00);
        wr(ADDR_WATCHDOG_COUNT, 16'h00ff);
        rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'h00);
        wr(ADDR_PERIODIC_CONTROL, 16'h4100);
        rdc("p_ctrl", ADDR_PERIODIC_CONTROL, 8'h00);
        tick(5);
        rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'h05);
        rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'h05);
        wr(ADDR_SERVICE_KEY, 16'h00aa);
        rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'h05);
        wr(ADDR_SERVICE_KEY, 16'h0055);
        wr(ADDR_SERVICE_KEY, 16'h0055);
        rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'h05);
        wr(ADDR_SERVICE_KEY, 16'h00aa);
        rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'h00);
        tick(3);
        wr(ADDR_SERVICE_KEY, 16'h00aa);
        rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'h03);
        svc();
        rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'h00);
        chk1("system_reset_req", 1'b0, system_reset_req);
        // every prescale code, counter cleared before each burst
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_WATCHDOG_CONTROL, 16'h0028 | 16'(s));
            svc();
            t0 = tk;
            tick(64);
            dv = (s < 2) ? 64 : (tk >> (s - 1)) - (t0 >> (s - 1));
            rdc("wd_cnt", ADDR_WATCHDOG_COUNT, 8'(dv));
        end
        svc();
        // periodic taps: free /4../128, then periodic-counter taps /512 and /2048
        for (int s = 0; s < 6; s++) begin
            dv = (s < 3) ? (4 << (2 * s)) : (128 << (2 * (s - 3)));
            wr(ADDR_PERIODIC_CONTROL, 16'h0040 | 16'(s));
            i0 = irq_n;
            t0 = tk;
            tick(2 * dv);
            chk("irq_count", 8'((tk / dv) - (t0 / dv)), 8'(irq_n - i0));
            rdc("p_ctrl", ADDR_PERIODIC_CONTROL, 8'hc0 | 8'(s));
            wr(ADDR_PERIODIC_CONTROL, 16'(s));
            rdc("p_ctrl", ADDR_PERIODIC_CONTROL, 8'(s));
            svc();
        end
        wr(ADDR_PERIODIC_CONTROL, 16'h0047);
        rdc("p_ctrl", ADDR_PERIODIC_CONTROL, 8'h47);
        wr(ADDR_PERIODIC_CONTROL, 16'h0000);
        i0 = irq_n;
        tick(8);
        chk("irq_count", 8'h00, 8'(irq_n - i0));
        rdc("p_ctrl", ADDR_PERIODIC_CONTROL, 8'h80);
        rdc("p_cnt", ADDR_PERIODIC_COUNT, 8'(tk >> 7));
        tick((228 - (tk % 128)) % 128);
        wr(ADDR_PERIODIC_COUNT, 16'h0033);
        rdc("p_cnt", ADDR_PERIODIC_COUNT, 8'h00);
        tick(40);
        // a cleared free counter would leave this at zero
        rdc("p_cnt", ADDR_PERIODIC_COUNT, 8'h01);
        wr(ADDR_WATCHDOG_CONTROL, 16'h0028);
        svc();
        tick(256);
        chk1("system_reset_req", 1'b0, system_reset_req);
        tick(1);
        wait_req(2);
        do_rst(1'b1);
        rdc("wd_ctrl", ADDR_WATCHDOG_CONTROL, 8'ha8);
        wr(ADDR_SERVICE_KEY, 16'h0023);
        wait_req(3);
        do_rst(1'b1);
        wr(ADDR_WATCHDOG_CONTROL, 16'h00a8);
        rdc("wd_ctrl", ADDR_WATCHDOG_CONTROL, 8'h28);
        wr(ADDR_WATCHDOG_CONTROL, 16'h0020);
        wait_req(4);
        do_rst(1'b1);
        rdc("wd_ctrl", ADDR_WATCHDOG_CONTROL, 8'ha8);
        do_rst(1'b0);
        rdc("wd_ctrl", ADDR_WATCHDOG_CONTROL, 8'h28);
        end_sim();
    end
endmodule : tb_wdpt_top
`default_nettype wire
